// ### cpc_defines.vh
`ifndef CPC_DEFINES_VH
`define CPC_DEFINES_VH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define CPC_OFF_CTRL      12'h000
`define CPC_OFF_OPTIONS   12'h004
`define CPC_OFF_STATUS    12'h008
`define CPC_OFF_DATA      12'h00c
`define CPC_OFF_COUNT     12'h010
`define CPC_OFF_INITLEN   12'h014
// ************************************************************
// control field positions
// ************************************************************
`define CPC_CTRL_MODE_LSB 0
`define CPC_CTRL_MODE_MSB 1
`define CPC_CTRL_FRAMELEN_LSB 8
`define CPC_CTRL_FRAMELEN_MSB 23
// ************************************************************
// option bits
// ************************************************************
`define CPC_OPT_USERCLK   0
`define CPC_OPT_INITDONE  1
`define CPC_OPT_GOE       2
`define CPC_OPT_GCLR      3
`define CPC_OPT_TRISTATE  4
`define CPC_OPT_DATA0USER 5
`define CPC_OPT_DUALHIGH  6
// ************************************************************
// scheme codes
// ************************************************************
`define CPC_MODE_PS       2'h0
`define CPC_MODE_FPP      2'h1
`define CPC_MODE_AS       2'h2
// ************************************************************
// reset values and first-frame bit count
// ************************************************************
`define CPC_CTRL_RST      32'h00001000
`define CPC_OPT_RST       32'h00000000
`define CPC_INITLEN_RST   16'h0020
`define CPC_FIRST_FRAME_BITS 16'h0010
`endif

// ### cpc_edge_sync.v
`timescale 1ns/100ps
// ************************************************************
// two-stage synchroniser with rising-edge pulse per bit
// ************************************************************
module cpc_edge_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input  wire             clk,
   input  wire             reset_n,
   // pins in
   input  wire [WIDTH-1:0] pinIn,
   // synchronised level and rising-edge pulse
   output wire [WIDTH-1:0] level,
   output wire [WIDTH-1:0] rise
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : gBit
         reg meta_r;
         reg sync_r;
         reg last_r;
         always @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
               last_r <= 1'b0;
            end else begin
               meta_r <= pinIn[i];
               sync_r <= meta_r;
               last_r <= sync_r;
            end
         end
         assign level[i] = sync_r;
         assign rise[i]  = sync_r & ~last_r;
      end
   endgenerate
endmodule // cpc_edge_sync

// ### cpc_config_pins.v
`timescale 1ns/100ps
`include "cpc_defines.vh"
// Notes on behaviour
// - serial schemes take one bit per configuration clock on serial data.
// - passive schemes sample data on configuration clock rising edge.
// - parallel scheme takes one whole byte per configuration clock.
// - serial schemes keep upper seven data pins tri-stated while loading.
// - after parallel load, upper data pins are user I/O per dual-purpose bit.
// - one variant keeps serial data input dedicated; other frees it later.
// - tri-state option floats clock, data, select, command in user mode.
// - disabled optional pins: user I/O, tri-stated with pull-up during load.
// - user start-up clock option times initialization from that clock.
// - completion flag is undriven while request is low and at load start.
// - completion flag driven low once its enable loads in first frame.
// - global output enable low tri-states all I/O when enabled (code gates only core_io_enable, parallel_data_oe and serial_data_oe).
// - global register clear low clears all registers when enabled.
// - chain enable output driven low once configuration is complete.
module cpc_config_pins #(
   parameter DEDICATED_SERIAL_CONFIG_DATA_IN = 1'b1,
   parameter INIT_CYCLES_W   = 16
) (
   // clock and reset
   input  wire        clk,
   input  wire        reset_n,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // configuration pins
   input  wire        configuration_request_n,
   input  wire        chain_enable_in_n,
   input  wire        config_clock_in,
   input  wire        serial_config_data_in,
   input  wire [7:1]  parallel_data_in,
   input  wire        user_startup_clock,
   input  wire        global_output_enable,
   input  wire        global_register_clear_n,
   // configuration clock / data pin drivers (self-driven scheme)
   output wire        config_clock_out,
   output wire        config_clock_oe,
   output wire        serial_data_oe,
   output wire        boot_memory_select_n,
   output wire        boot_memory_select_oe,
   output wire        boot_memory_command_out,
   output wire        boot_memory_command_oe,
   // upper parallel data pins as user I/O
   output wire [7:1]  parallel_data_out,
   output wire [7:1]  parallel_data_oe,
   // open-drain status pins
   output wire        init_done_out,
   output wire        init_done_oe,
   output wire        chain_enable_out_n,
   output wire        chain_enable_oe,
   // optional pins pulled up while tri-stated
   output wire        optional_pullup_en,
   // core-wide controls
   output wire        core_io_enable,
   output wire        core_clear_n,
   output wire        user_mode
);
   // ************************************************************
   // states
   // ************************************************************
   localparam ST_IDLE = 2'h0;
   localparam ST_LOAD = 2'h1;
   localparam ST_INIT = 2'h2;
   localparam ST_USER = 2'h3;

   reg  [1:0]  state_r;
   reg  [31:0] ctrl_r;
   reg  [31:0] opt_r;
   reg  [15:0] initLen_r;
   reg  [31:0] dataShift_r;
   reg  [15:0] bitCount_r;
   reg  [INIT_CYCLES_W-1:0] initCount_r;
   reg  [7:0]  lastByte_r;
   reg         initDoneEnLoaded_r;
   reg         initDoneEdge_r;
   reg         initDoneSeen_r;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   wire [12:0] syncLvl;
   wire [12:0] syncRise;
   cpc_edge_sync #(.WIDTH(13)) uSync (
      .clk     (clk),
      .reset_n (reset_n),
      .pinIn   ({global_register_clear_n, global_output_enable,
                 user_startup_clock, parallel_data_in,
                 serial_config_data_in, config_clock_in,
                 configuration_request_n}),
      .level   (syncLvl),
      .rise    (syncRise)
   );
   wire       reqN     = syncLvl[0];
   wire       cclkRise = syncRise[1];
   wire [7:0] dataByte = syncLvl[9:2];
   wire       uclkRise = syncRise[10];
   wire       goeLvl   = syncLvl[11];
   wire       gclrLvl  = syncLvl[12];

   wire [1:0]  mode     = ctrl_r[`CPC_CTRL_MODE_MSB:`CPC_CTRL_MODE_LSB];
   wire [15:0] frameLen = ctrl_r[`CPC_CTRL_FRAMELEN_MSB:
                                 `CPC_CTRL_FRAMELEN_LSB];
   wire        isFpp    = (mode == `CPC_MODE_FPP);
   wire        isAs     = (mode == `CPC_MODE_AS);

   // ************************************************************
   // self-driven scheme clock divider (one-cycle enable)
   // ************************************************************
   reg asClk_r;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         asClk_r <= 1'b0;
      end else if (state_r == ST_LOAD && isAs) begin
         asClk_r <= ~asClk_r;
      end else begin
         asClk_r <= 1'b0;
      end
   end
   // sample on the rising half of the driven clock
   wire asSample = (state_r == ST_LOAD) && isAs && !asClk_r;
   wire takeData = isAs ? asSample : cclkRise;

   // init timing source: user clock edge or own clock
   wire initTick = opt_r[`CPC_OPT_USERCLK] ? uclkRise : 1'b1;

   // ************************************************************
   // configuration sequencer
   // ************************************************************
   wire [15:0] stepBits = isFpp ? 16'h0008 : 16'h0001;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r            <= ST_IDLE;
         dataShift_r        <= 32'h00000000;
         bitCount_r         <= 16'h0000;
         initCount_r        <= {INIT_CYCLES_W{1'b0}};
         lastByte_r         <= 8'h00;
         initDoneEnLoaded_r <= 1'b0;
      end else if (!reqN) begin
         // request held low restarts the sequence but keeps captured data
         state_r            <= ST_IDLE;
         bitCount_r         <= 16'h0000;
         initDoneEnLoaded_r <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               bitCount_r  <= 16'h0000;
               initCount_r <= {INIT_CYCLES_W{1'b0}};
               if (!chain_enable_in_n) begin
                  state_r <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               if (takeData) begin
                  if (isFpp) begin
                     dataShift_r <= {dataShift_r[23:0], dataByte};
                     lastByte_r  <= dataByte;
                  end else begin
                     dataShift_r <= {dataShift_r[30:0], dataByte[0]};
                  end
                  bitCount_r <= bitCount_r + stepBits;
                  if (bitCount_r + stepBits >= `CPC_FIRST_FRAME_BITS &&
                      bitCount_r < `CPC_FIRST_FRAME_BITS) begin
                     initDoneEnLoaded_r <= opt_r[`CPC_OPT_INITDONE];
                  end
                  if (bitCount_r + stepBits >= frameLen) begin
                     state_r <= ST_INIT;
                  end
               end
            end
            ST_INIT: begin
               if (initTick) begin
                  initCount_r <= initCount_r + 1'b1;
                  if (initCount_r[15:0] + 16'h0001 >= initLen_r) begin
                     state_r <= ST_USER;
                  end
               end
            end
            default: begin
               state_r <= ST_USER;
            end
         endcase
      end
   end

   // completion-flag edge seen by software (set wins over clear)
   wire initDoneReleased = (state_r == ST_USER);
   reg  stsClr;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         initDoneEdge_r <= 1'b0;
         initDoneSeen_r <= 1'b0;
      end else begin
         initDoneEdge_r <= initDoneReleased;
         if (initDoneReleased && !initDoneEdge_r) begin
            initDoneSeen_r <= 1'b1;
         end else if (stsClr) begin
            initDoneSeen_r <= 1'b0;
         end
      end
   end

   // ************************************************************
   // pin drivers
   // ************************************************************
   wire inUser   = (state_r == ST_USER);
   wire cfgPhase = !inUser;
   wire triAct   = inUser && opt_r[`CPC_OPT_TRISTATE];
   wire ioOk     = !opt_r[`CPC_OPT_GOE] || goeLvl;

   assign init_done_out = 1'b0;
   // drive low only after enable loaded, until initialization ends
   assign init_done_oe  = initDoneEnLoaded_r && (state_r == ST_INIT ||
                          (state_r == ST_LOAD));
   assign chain_enable_out_n = 1'b0;
   assign chain_enable_oe    = inUser;

   assign config_clock_out        = asClk_r;
   assign config_clock_oe         = isAs && !triAct;
   assign boot_memory_select_n    = !(state_r == ST_LOAD && isAs);
   assign boot_memory_select_oe   = isAs && !triAct;
   assign boot_memory_command_out = 1'b0;
   assign boot_memory_command_oe  = isAs && !triAct;
   // data input never driven in tri-state user mode or dedicated variant
   assign serial_data_oe = inUser && !DEDICATED_SERIAL_CONFIG_DATA_IN && !triAct &&
                           opt_r[`CPC_OPT_DATA0USER] && ioOk;

   // upper data pins: tri-stated while loading, user I/O afterwards
   assign parallel_data_out = {7{opt_r[`CPC_OPT_DUALHIGH]}};
   assign parallel_data_oe  = {7{inUser && ioOk}};
   assign optional_pullup_en = cfgPhase;

   assign core_io_enable = inUser && ioOk;
   assign core_clear_n   = !(opt_r[`CPC_OPT_GCLR] && !gclrLvl);
   assign user_mode      = inUser;

   // ************************************************************
   // apb registers
   // ************************************************************
   wire wrEn = psel && penable && pwrite;
   wire rdEn = psel && penable && !pwrite;
   reg  mapped;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always @* begin
      if (paddr == `CPC_OFF_CTRL || paddr == `CPC_OFF_OPTIONS ||
          paddr == `CPC_OFF_STATUS || paddr == `CPC_OFF_DATA ||
          paddr == `CPC_OFF_COUNT || paddr == `CPC_OFF_INITLEN) begin
         mapped = 1'b1;
      end else begin
         mapped = 1'b0;
      end
      stsClr = wrEn && (paddr == `CPC_OFF_STATUS) && pwdata[4];
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r    <= `CPC_CTRL_RST;
         opt_r     <= `CPC_OPT_RST;
         initLen_r <= `CPC_INITLEN_RST;
      end else if (wrEn) begin
         if (paddr == `CPC_OFF_CTRL) begin
            ctrl_r <= pwdata;
         end else if (paddr == `CPC_OFF_OPTIONS) begin
            opt_r <= pwdata;
         end else if (paddr == `CPC_OFF_INITLEN) begin
            initLen_r <= pwdata[15:0];
         end
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         if (paddr == `CPC_OFF_CTRL) begin
            prdata <= ctrl_r;
         end else if (paddr == `CPC_OFF_OPTIONS) begin
            prdata <= opt_r;
         end else if (paddr == `CPC_OFF_STATUS) begin
            prdata <= {24'h000000, lastByte_r[2:0], initDoneSeen_r,
                       initDoneEnLoaded_r, inUser, state_r};
         end else if (paddr == `CPC_OFF_DATA) begin
            prdata <= dataShift_r;
         end else if (paddr == `CPC_OFF_COUNT) begin
            prdata <= {16'h0000, bitCount_r};
         end else if (paddr == `CPC_OFF_INITLEN) begin
            prdata <= {16'h0000, initLen_r};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end
endmodule // cpc_config_pins

// ### cpc_chk.sv
`timescale 1ns/100ps
`include "cpc_defines.vh"
// ****************************************
// configuration pin checker
// ****************************************
module cpc_chk #(
   parameter DEDICATED_SERIAL_CONFIG_DATA_IN = 1'b1
) (
   // clock and reset
   input wire        clk,
   input wire        reset_n,
   // apb, watched only to shadow the options
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   // pins
   input wire        configuration_request_n,
   input wire        global_output_enable,
   input wire        global_register_clear_n,
   input wire        config_clock_oe,
   input wire        serial_data_oe,
   input wire        boot_memory_select_oe,
   input wire        boot_memory_command_oe,
   input wire [7:1]  parallel_data_out,
   input wire [7:1]  parallel_data_oe,
   input wire        init_done_out,
   input wire        init_done_oe,
   input wire        chain_enable_out_n,
   input wire        chain_enable_oe,
   input wire        optional_pullup_en,
   input wire        core_io_enable,
   input wire        core_clear_n,
   input wire        user_mode
);
   reg [31:0] optR_r;
   // option bits are internal, so rebuild them from completed writes
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         optR_r <= 32'h0;
      else if (psel && penable && pwrite && pready &&
               paddr == `CPC_OFF_OPTIONS)
         optR_r <= pwdata;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_pullup_cfg: assert property (optional_pullup_en == !user_mode)
      else $error("pull-up enable wrong");
   a_upper_float: assert property (!user_mode |->
      parallel_data_oe == 7'h0) else $error("upper data driven during load");
   a_upper_release: assert property (user_mode && core_io_enable |->
      parallel_data_oe == 7'h7f && parallel_data_out == {7{optR_r[6]}})
      else $error("upper data not released");
   a_req_floats: assert property (!configuration_request_n [*4] |->
      !init_done_oe) else $error("done flag driven while held");
   a_done_low: assert property (init_done_oe |-> !init_done_out &&
      !user_mode && optR_r[1]) else $error("done flag low wrongly");
   a_user_release: assert property ($rose(user_mode) |->
      !init_done_oe && ($past(init_done_oe) || !optR_r[1]))
      else $error("done not released");
   a_goe_float: assert property (
      (optR_r[2] && !global_output_enable) [*4]
      |-> !core_io_enable && parallel_data_oe == 7'h0)
      else $error("outputs not tri-stated");
   a_gclr_clear: assert property (
      (optR_r[3] && !global_register_clear_n) [*4] |-> !core_clear_n)
      else $error("registers not cleared");
   a_chain_out: assert property (chain_enable_oe == user_mode &&
      !chain_enable_out_n) else $error("chain output wrong");
   a_act_float: assert property (user_mode && optR_r[4] |->
      !(config_clock_oe || boot_memory_select_oe || boot_memory_command_oe
      || serial_data_oe)) else $error("active pins not tri-stated");
   a_data_dedic: assert property (DEDICATED_SERIAL_CONFIG_DATA_IN != 0 || !user_mode |->
      !serial_data_oe) else $error("dedicated data pin driven");
   c_user: cover property ($rose(user_mode));
   c_done: cover property ($rose(init_done_oe));
   c_goe: cover property ($fell(core_io_enable));
endmodule // cpc_chk

bind cpc_config_pins cpc_chk #(.DEDICATED_SERIAL_CONFIG_DATA_IN(DEDICATED_SERIAL_CONFIG_DATA_IN)) chk (
   .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .configuration_request_n, .global_output_enable, .global_register_clear_n,
   .config_clock_oe, .serial_data_oe, .boot_memory_select_oe,
   .boot_memory_command_oe, .parallel_data_out, .parallel_data_oe,
   .init_done_out, .init_done_oe, .chain_enable_out_n, .chain_enable_oe,
   .optional_pullup_en, .core_io_enable, .core_clear_n, .user_mode);

// ### cpc_host_model.sv
`timescale 1ns/100ps
// ****************************************
// external configuration host
// ****************************************
module cpc_host_model (
   // pins toward the device
   output reg       cfgClk,
   output reg       serData,
   output reg [7:1] parData,
   output wire      chainInN,
   // completion line as seen on the board
   input  wire      doneLine
);
   integer rises;
   assign chainInN = 1'b0;
   // lines start quiet; this host never wiggles any jtag line
   initial begin
      cfgClk = 1'b0;
      serData = 1'b0;
      parData = 7'h0;
      rises = 0;
   end
   // the monitor treats a rising completion line as user mode
   always @(posedge doneLine) rises = rises + 1;
   // clock is still between frames; data changes only while it is low
   task send_byte(input logic [7:0] b, input logic fast_passive_parallel_mode);
      integer i;
      if (fast_passive_parallel_mode) begin
         {parData, serData} = b;
         #160 cfgClk = 1'b1;
         #160 cfgClk = 1'b0;
      end else begin
         for (i = 7; i >= 0; i = i - 1) begin
            serData = b[i];
            #160 cfgClk = 1'b1;
            #160 cfgClk = 1'b0;
         end
      end
   endtask
   // a boot memory streaming one level answers the self-driven scheme
   task drive_bit(input logic b);
      serData = b;
   endtask
   // released lines do not keep their last value
   task stop;
      serData = ~serData;
      parData = ~parData;
   endtask
endmodule // cpc_host_model

// ### config_pin_control_tb_top.sv
`timescale 1ns/100ps
`include "cpc_defines.vh"
// ****************************************
// bench for the configuration pin block
// ****************************************
module config_pin_control_tb_top;
   reg         clk, reset_n, psel, penable, pwrite, ucRun;
   reg  [11:0] paddr;
   reg  [31:0] pwdata;
   reg  [2:0]  ucCnt;
   reg         configuration_request_n, user_startup_clock;
   reg         global_output_enable, global_register_clear_n;
   wire [31:0] prdata;
   wire        pready, pslverr, config_clock_in, serial_config_data_in;
   wire [7:1]  parallel_data_in, parallel_data_out, parallel_data_oe;
   wire        init_done_out, init_done_oe, chain_enable_in_n;
   wire        chain_enable_oe, core_io_enable, core_clear_n, user_mode;
   wire        cclkOe, memSelN, memSelOe;
   integer     miscompares, cmp_count, cycles;
   // open-drain line with its external pull-up
   wire        doneLvl = init_done_oe ? init_done_out : 1'b1;
   cpc_config_pins #(.DEDICATED_SERIAL_CONFIG_DATA_IN(1'b1)) uut (
      .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .configuration_request_n, .chain_enable_in_n,
      .config_clock_in, .serial_config_data_in, .parallel_data_in,
      .user_startup_clock, .global_output_enable, .global_register_clear_n,
      .config_clock_out(), .config_clock_oe(cclkOe), .serial_data_oe(),
      .boot_memory_select_n(memSelN), .boot_memory_select_oe(memSelOe),
      .boot_memory_command_out(), .boot_memory_command_oe(),
      .parallel_data_out, .parallel_data_oe, .init_done_out, .init_done_oe,
      .chain_enable_out_n(), .chain_enable_oe, .optional_pullup_en(),
      .core_io_enable, .core_clear_n, .user_mode);
   cpc_host_model host (.cfgClk(config_clock_in),
      .serData(serial_config_data_in), .parData(parallel_data_in),
      .chainInN(chain_enable_in_n), .doneLine(doneLvl));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (ucRun) begin
         ucCnt <= ucCnt + 3'h1;
         user_startup_clock <= ucCnt[2];
      end else begin
         ucCnt <= 3'h0;
         user_startup_clock <= 1'b0;
      end
   end
   // about 850 cycles are needed; hang cut well above that
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         report_and_stop;
      end
   end
   task check32(input string nm, input logic [31:0] exp,
                input logic [31:0] got);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task rdchk(input string nm, input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check32(nm, x, r);
   endtask
   task do_reset;
      reset_n <= 1'b0;
      configuration_request_n <= 1'b0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
   endtask
   task wait_user(input integer n);
      integer k;
      k = 0;
      while (user_mode !== 1'b1 && k < n) begin
         @(posedge clk);
         k = k + 1;
      end
   endtask
   task test_regs;
      logic [31:0] r;
      logic e;
      rdchk("ctrl", `CPC_OFF_CTRL, `CPC_CTRL_RST);
      rdchk("options", `CPC_OFF_OPTIONS, `CPC_OPT_RST);
      rdchk("initlen", `CPC_OFF_INITLEN, {16'h0, `CPC_INITLEN_RST});
      apb(1'b0, 12'h018, 32'h0, r, e);
      check32("unmapped data", 32'h0, r);
      check32("unmapped err", 32'h1, {31'h0, e});
      $display("test_regs done");
   endtask
   task test_serial;
      integer r0;
      do_reset;
      wr(`CPC_OFF_OPTIONS, 32'h2);
      wr(`CPC_OFF_CTRL, {8'h0, 16'h0018, 6'h0, `CPC_MODE_PS});
      repeat (4) @(posedge clk);
      check32("done held", 32'h1, doneLvl);
      configuration_request_n <= 1'b1;
      repeat (4) @(posedge clk);
      host.send_byte(8'ha5, 1'b0);
      host.send_byte(8'hc3, 1'b0);
      repeat (4) @(posedge clk);
      check32("done low", 32'h0, doneLvl);
      r0 = host.rises;
      host.send_byte(8'he1, 1'b0);
      host.stop;
      wait_user(1000);
      check32("user", 32'h1, user_mode);
      check32("done rises", r0 + 1, host.rises);
      check32("chain oe", 32'h1, chain_enable_oe);
      rdchk("status", `CPC_OFF_STATUS, 32'h1f);
      wr(`CPC_OFF_STATUS, 32'h10);
      rdchk("status clr", `CPC_OFF_STATUS, 32'h0f);
      rdchk("count", `CPC_OFF_COUNT, 32'd24);
      rdchk("data", `CPC_OFF_DATA, 32'h00a5c3e1);
      $display("test_serial done");
   endtask
   task test_fpp;
      do_reset;
      wr(`CPC_OFF_OPTIONS, 32'h5d);
      wr(`CPC_OFF_CTRL, {8'h0, 16'h0020, 6'h0, `CPC_MODE_FPP});
      configuration_request_n <= 1'b1;
      repeat (4) @(posedge clk);
      host.send_byte(8'h12, 1'b1);
      host.send_byte(8'h34, 1'b1);
      host.send_byte(8'h56, 1'b1);
      host.send_byte(8'h78, 1'b1);
      host.stop;
      repeat (100) @(posedge clk);
      check32("user early", 32'h0, user_mode);
      ucRun <= 1'b1;
      wait_user(1000);
      check32("user", 32'h1, user_mode);
      rdchk("count", `CPC_OFF_COUNT, 32'd32);
      rdchk("data", `CPC_OFF_DATA, 32'h12345678);
      check32("upper oe", 32'h7f, parallel_data_oe);
      check32("upper out", 32'h7f, parallel_data_out);
      global_output_enable <= 1'b0;
      repeat (4) @(posedge clk);
      check32("io enable", 32'h0, core_io_enable);
      check32("upper off", 32'h0, parallel_data_oe);
      global_register_clear_n <= 1'b0;
      repeat (4) @(posedge clk);
      check32("clear", 32'h0, core_clear_n);
      global_output_enable <= 1'b1;
      global_register_clear_n <= 1'b1;
      ucRun <= 1'b0;
      $display("test_fpp done");
   endtask
   task test_as;
      do_reset;
      host.drive_bit(1'b1);
      wr(`CPC_OFF_OPTIONS, 32'h10);
      wr(`CPC_OFF_CTRL, {8'h0, 16'h0018, 6'h0, `CPC_MODE_AS});
      configuration_request_n <= 1'b1;
      repeat (4) @(posedge clk);
      check32("memory select", 32'h0, memSelN);
      check32("clock oe", 32'h1, cclkOe);
      wait_user(1000);
      check32("user", 32'h1, user_mode);
      rdchk("count", `CPC_OFF_COUNT, 32'd24);
      rdchk("data", `CPC_OFF_DATA, 32'h00ffffff);
      check32("clock off", 32'h0, cclkOe);
      check32("select off", 32'h0, memSelOe);
      $display("test_as done");
   endtask
   task report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      miscompares = 0;
      cmp_count = 0;
      cycles = 0;
      reset_n = 1'b0;
      {psel, penable, pwrite, ucRun} = 4'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      configuration_request_n = 1'b0;
      global_output_enable = 1'b1;
      global_register_clear_n = 1'b1;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      test_regs;
      test_serial;
      test_fpp;
      test_as;
      report_and_stop;
   end
endmodule // config_pin_control_tb_top
